/* File: hw/nzs_map.svh */
`ifndef NZS_MAP_SVH
`define NZS_MAP_SVH
// Operation codes on the request port
`define NZS_OP_NONE 3'h0
`define NZS_OP_SWAP 3'h1
`define NZS_OP_SZ 3'h2
`define NZS_OP_SZA 3'h3
`define NZS_OP_SBIT 3'h4
// Instruction cycles taken by a test whose skip is taken
`define NZS_SKIP_CYCLES 2'h3
// Count after the first cycle of a skip, and for a plain instruction
`define NZS_SKIP_FIRST 2'h2
`define NZS_ONE_CYCLE 2'h1
`define NZS_CYCLES_RESET 2'h0
`define NZS_ACCUM_RESET 8'h00
`define NZS_DATA_ZERO 8'h00
`endif

/* File: hw/nzs_pkg.sv */
package nzs_pkg;
  typedef enum logic [1:0] {
    NZS_IDLE,
    NZS_EXEC,
    NZS_DUMMY
  } nzs_state_type;

  // Request from the decode stage: operation, memory operand, bit select
  typedef struct packed {
    logic [2:0] op;
    logic [7:0] operand;
    logic [2:0] bit_sel;
    logic [7:0] address;
  } nzs_req_type;

  // Write-back to the data memory
  typedef struct packed {
    logic we;
    logic [7:0] address;
    logic [7:0] data;
  } nzs_mem_wr_type;
endpackage : nzs_pkg

/* File: hw/nzs_eval.sv */
`timescale 1ns/10ps
`include "nzs_map.svh"
// Pure decode of one request: result value and skip decision
module nzs_eval (
  // Request
  input wire nzs_pkg::nzs_req_type req_in,
  // Results
  output logic [7:0] swap_out,
  output logic skip_out,
  output logic accum_we_out,
  output logic mem_we_out
);
  wire is_swap = (req_in.op == `NZS_OP_SWAP);
  wire is_sz = (req_in.op == `NZS_OP_SZ);
  wire is_sza = (req_in.op == `NZS_OP_SZA);
  wire is_sbit = (req_in.op == `NZS_OP_SBIT);
  wire is_zero = (req_in.operand == `NZS_DATA_ZERO);
  wire sel_bit = req_in.operand[req_in.bit_sel];

  assign swap_out = {req_in.operand[3:0], req_in.operand[7:4]};
  assign skip_out = ((is_sz | is_sza) & is_zero) | (is_sbit & ~sel_bit);
  assign accum_we_out = is_swap | is_sza;
  assign mem_we_out = is_sz;
endmodule : nzs_eval

/* File: hw/nzs_core.sv */
`timescale 1ns/10ps
`include "nzs_map.svh"
module nzs_core (
  // Clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RSTN_IN,
  // Request from decode, valid for one cycle
  input wire logic REQ_VALID_IN,
  input wire nzs_pkg::nzs_req_type REQ_IN,
  // Accumulator write
  output logic ACCUM_WE_OUT,
  output logic [7:0] ACCUM_DATA_OUT,
  // Data memory write-back
  output nzs_pkg::nzs_mem_wr_type MEM_WR_OUT,
  // Pipeline control
  output logic SKIP_OUT,
  output logic BUSY_OUT,
  output logic DONE_OUT,
  output logic FLAGS_WE_OUT
);
  nzs_pkg::nzs_state_type state_r, state_nxt;
  nzs_pkg::nzs_mem_wr_type mem_wr_nxt;
  logic [7:0] swap_val;
  logic skip_val;
  logic accum_we_val;
  logic mem_we_val;
  logic [1:0] cycles_r;
  logic [1:0] cycles_nxt;

  // Op compare shared by the datapath and the checks
  function automatic logic op_is(input logic [2:0] op, input logic [2:0] code);
    op_is = (op == code);
  endfunction : op_is

  nzs_eval u_eval (
    .req_in(REQ_IN),
    .swap_out(swap_val),
    .skip_out(skip_val),
    .accum_we_out(accum_we_val),
    .mem_we_out(mem_we_val)
  );

  // Requests in the dummy slot are dropped; decode must leave that cycle empty
  wire in_dummy = (state_r == nzs_pkg::NZS_DUMMY);
  wire take = REQ_VALID_IN & ~in_dummy;
  wire is_swap = op_is(REQ_IN.op, `NZS_OP_SWAP);
  wire is_sz = op_is(REQ_IN.op, `NZS_OP_SZ);
  wire is_sza = op_is(REQ_IN.op, `NZS_OP_SZA);
  wire is_sbit = op_is(REQ_IN.op, `NZS_OP_SBIT);
  wire is_zero = (REQ_IN.operand == `NZS_DATA_ZERO);
  wire [7:0] accum_val = is_swap ? swap_val : REQ_IN.operand;
  // A dummy cycle follows a taken skip, stalling the fetch
  wire go_dummy = take & skip_val;
  wire finish_now = take & ~skip_val;

  always_comb begin
    case (state_r)
      nzs_pkg::NZS_IDLE: state_nxt = go_dummy ? nzs_pkg::NZS_DUMMY : nzs_pkg::NZS_IDLE;
      nzs_pkg::NZS_EXEC: state_nxt = go_dummy ? nzs_pkg::NZS_DUMMY : nzs_pkg::NZS_IDLE;
      nzs_pkg::NZS_DUMMY: state_nxt = nzs_pkg::NZS_EXEC;
      default: state_nxt = nzs_pkg::NZS_IDLE;
    endcase
  end

  // Length of the instruction now finishing; read only by the timing checks
  assign cycles_nxt = go_dummy ? `NZS_SKIP_FIRST : (in_dummy ? `NZS_SKIP_CYCLES : `NZS_ONE_CYCLE);

  always_ff @(posedge REF_CLK_IN) begin
    if (!RSTN_IN) begin
      state_r <= nzs_pkg::NZS_IDLE;
      cycles_r <= `NZS_CYCLES_RESET;
    end else begin
      state_r <= state_nxt;
      cycles_r <= cycles_nxt;
    end
  end

  // Timing of a taken skip and of a plain instruction
  a_dummy_cycle: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    go_dummy
    |=> BUSY_OUT && !DONE_OUT ##1 BUSY_OUT && DONE_OUT && cycles_r == `NZS_SKIP_CYCLES)
    else $error("skip not three cycles");
  a_busy_shape: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    BUSY_OUT && !DONE_OUT
    |=> BUSY_OUT && DONE_OUT)
    else $error("stall not two cycles");
  a_skip_pulse: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    SKIP_OUT
    |=> !SKIP_OUT)
    else $error("skip longer than one cycle");
  a_single_cycle: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    finish_now
    |=> DONE_OUT && !BUSY_OUT && cycles_r == `NZS_ONE_CYCLE)
    else $error("not one cycle");
  a_op_none: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    take && op_is(REQ_IN.op, `NZS_OP_NONE)
    |=> DONE_OUT && !ACCUM_WE_OUT && !MEM_WR_OUT.we && !SKIP_OUT)
    else $error("empty op had an effect");
  a_idle_quiet: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    !REQ_VALID_IN && !in_dummy
    |=> !DONE_OUT && !ACCUM_WE_OUT && !MEM_WR_OUT.we && !BUSY_OUT)
    else $error("activity without request");
  a_dummy_refused: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    REQ_VALID_IN && in_dummy
    |=> !ACCUM_WE_OUT && !MEM_WR_OUT.we && !SKIP_OUT)
    else $error("request taken in dummy slot");

  wire accum_we_nxt = take & accum_we_val;
  // Held between writes so a rewrite or bit test never disturbs it
  wire [7:0] accum_data_nxt = accum_we_nxt ? accum_val : ACCUM_DATA_OUT;

  always_ff @(posedge REF_CLK_IN) begin
    if (!RSTN_IN) begin
      ACCUM_WE_OUT <= 1'b0;
      ACCUM_DATA_OUT <= `NZS_ACCUM_RESET;
    end else begin
      ACCUM_WE_OUT <= accum_we_nxt;
      ACCUM_DATA_OUT <= accum_data_nxt;
    end
  end

  // Accumulator port
  a_swap_value: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    take && is_swap
    |=> ACCUM_WE_OUT && ACCUM_DATA_OUT == {$past(REQ_IN.operand[3:0]), $past(REQ_IN.operand[7:4])})
    else $error("swap result wrong");
  a_load_copy: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    take && is_sza
    |=> ACCUM_WE_OUT && ACCUM_DATA_OUT == $past(REQ_IN.operand))
    else $error("load copy wrong");
  a_accum_hold: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    !ACCUM_WE_OUT
    |-> $stable(ACCUM_DATA_OUT))
    else $error("accumulator changed without write");

  // Address and data always follow the request; only the strobe qualifies them
  assign mem_wr_nxt = '{we: take & mem_we_val, address: REQ_IN.address, data: REQ_IN.operand};

  always_ff @(posedge REF_CLK_IN) begin
    if (!RSTN_IN) begin
      MEM_WR_OUT <= '0;
    end else begin
      MEM_WR_OUT <= mem_wr_nxt;
    end
  end

  // Data memory write-back
  a_swap_no_write: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    take && is_swap
    |=> !MEM_WR_OUT.we)
    else $error("swap wrote memory");
  a_rewrite_same: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    take && is_sz
    |=> MEM_WR_OUT.we && MEM_WR_OUT.data == $past(REQ_IN.operand))
    else $error("rewrite value wrong");
  a_rewrite_addr: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    take && is_sz
    |=> MEM_WR_OUT.address == $past(REQ_IN.address))
    else $error("rewrite address wrong");
  a_write_source: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    MEM_WR_OUT.we
    |-> $past(take && is_sz))
    else $error("memory written by wrong op");
  a_load_no_write: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    take && is_sza
    |=> !MEM_WR_OUT.we)
    else $error("load wrote memory");
  a_bit_no_write: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    take && is_sbit
    |=> !ACCUM_WE_OUT && !MEM_WR_OUT.we)
    else $error("bit test wrote a result");

  always_ff @(posedge REF_CLK_IN) begin
    if (!RSTN_IN) begin
      SKIP_OUT <= 1'b0;
      BUSY_OUT <= 1'b0;
      DONE_OUT <= 1'b0;
      FLAGS_WE_OUT <= 1'b0;
    end else begin
      SKIP_OUT <= go_dummy;
      BUSY_OUT <= go_dummy | in_dummy;
      // Done on the final cycle: at once without skip, after the dummy cycle otherwise
      DONE_OUT <= finish_now | in_dummy;
      // Tied low, yet kept in a flop so every port leaves a register
      FLAGS_WE_OUT <= 1'b0;
    end
  end

  // Skip decision and pipeline control
  a_zero_skips: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    take && (is_sz || is_sza) && is_zero
    |=> SKIP_OUT ##1 DONE_OUT)
    else $error("zero did not skip");
  a_nonzero_runs: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    take && is_sz && !is_zero
    |=> !SKIP_OUT && !BUSY_OUT && DONE_OUT)
    else $error("nonzero skipped");
  a_load_nonzero: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    take && is_sza && !is_zero
    |=> !SKIP_OUT && !BUSY_OUT && DONE_OUT)
    else $error("nonzero load skipped");
  a_bit_test: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    take && is_sbit
    |=> SKIP_OUT == !$past(REQ_IN.operand[REQ_IN.bit_sel]))
    else $error("bit test wrong");
  a_swap_no_skip: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    take && is_swap
    |=> !SKIP_OUT && !BUSY_OUT && DONE_OUT)
    else $error("swap skipped");
  a_no_flags: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    !FLAGS_WE_OUT)
    else $error("flags written");
endmodule : nzs_core

/* File: testbench/nzs_core_tb.sv */
`timescale 1ns/10ps
`include "nzs_map.svh"
module nzs_core_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic req_valid = 1'b0;
  nzs_pkg::nzs_req_type req = '0;
  logic accum_we, skip, busy, done, flags_we;
  logic [7:0] accum_data;
  nzs_pkg::nzs_mem_wr_type mem_wr;
  int fail_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  always #25 clk = ~clk;
  nzs_core uut (.REF_CLK_IN(clk), .RSTN_IN(rstn), .REQ_VALID_IN(req_valid), .REQ_IN(req),
    .ACCUM_WE_OUT(accum_we), .ACCUM_DATA_OUT(accum_data), .MEM_WR_OUT(mem_wr), .SKIP_OUT(skip),
    .BUSY_OUT(busy), .DONE_OUT(done), .FLAGS_WE_OUT(flags_we));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task report_and_stop;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  // One request, then judge the answer cycle and, if skipping, the done cycle after the dummy cycle
  task run_op(input logic [2:0] op, input logic [7:0] opd, input logic [2:0] bs,
              input logic exp_we, input logic [7:0] exp_acc, input logic exp_skip);
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{op, opd, bs, 8'h5A};
    @(posedge clk);
    req_valid <= 1'b0;
    #1;
    chk(accum_we, exp_we);
    if (exp_we) chk(accum_data, exp_acc);
    chk(mem_wr.we, op == `NZS_OP_SZ);
    if (op == `NZS_OP_SZ) chk({mem_wr.address, mem_wr.data}, {8'h5A, opd});
    chk({skip, busy, done}, {exp_skip, exp_skip, !exp_skip});
    chk(flags_we, 1'b0);
    if (exp_skip) begin
      @(posedge clk);
      #1;
      chk({skip, busy, done}, 3'b011);
    end
  endtask : run_op
  task t_swap;
    run_op(`NZS_OP_SWAP, 8'h12, 3'h0, 1'b1, 8'h21, 1'b0);
    run_op(`NZS_OP_SWAP, 8'hF0, 3'h0, 1'b1, 8'h0F, 1'b0);
    run_op(`NZS_OP_NONE, 8'h00, 3'h0, 1'b0, 8'h00, 1'b0);
  endtask : t_swap
  task t_rewrite;
    run_op(`NZS_OP_SZ, 8'h00, 3'h0, 1'b0, 8'h00, 1'b1);
    run_op(`NZS_OP_SZ, 8'h80, 3'h0, 1'b0, 8'h00, 1'b0);
  endtask : t_rewrite
  task t_load;
    run_op(`NZS_OP_SZA, 8'h00, 3'h0, 1'b1, 8'h00, 1'b1);
    run_op(`NZS_OP_SZA, 8'h01, 3'h0, 1'b1, 8'h01, 1'b0);
  endtask : t_load
  task t_bit;
    for (int i = 0; i < 8; i++) begin
      run_op(`NZS_OP_SBIT, ~(8'h01 << i), i[2:0], 1'b0, 8'h00, 1'b1);
      run_op(`NZS_OP_SBIT, 8'h01 << i, i[2:0], 1'b0, 8'h00, 1'b0);
    end
  endtask : t_bit
  // A swap held into the dummy cycle must be dropped
  task t_dummy;
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{`NZS_OP_SZ, 8'h00, 3'h0, 8'h11};
    @(posedge clk);
    req <= '{`NZS_OP_SWAP, 8'h34, 3'h0, 8'h11};
    @(posedge clk);
    req_valid <= 1'b0;
    #1;
    chk({accum_we, done}, 2'b01);
    chk(accum_data, 8'h01);
    @(posedge clk);
    #1;
    chk({accum_we, done}, 2'b00);
  endtask : t_dummy
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      fail_count++;
      report_and_stop();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    t_swap();
    t_rewrite();
    t_load();
    t_bit();
    t_dummy();
    report_and_stop();
  end
endmodule : nzs_core_tb
